// file: bench/frg_flash_model.sv
`timescale 1ns/1ns
// Flash engine stand-in: ends each started job after a short or long delay.
module frg_flash_model #(
   parameter int QUICK = 3,  // Short job in cycles.
   parameter int SLOW  = 40  // Long job, so busy can be probed.
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic slow,
   output logic     done
);
   logic [7:0] cnt_r; // Cycles left in the job.
   // A start reloads the count; done pulses for one cycle at one.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (go) begin
         cnt_r <= slow ? 8'(SLOW) : 8'(QUICK);
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   assign done = cnt_r == 8'h01;
endmodule

// file: bench/frg_guard_properties.sv
`timescale 1ns/1ns
// Watches the guard's pins: start pulses, busy flags, locks and reads.
module frg_guard_properties (
   input wire logic        REF_CLK,
   input wire logic        RESETN,
   input wire logic [15:0] SFR_ADDR,
   input wire logic        SFR_WE,
   input wire logic        SFR_RE,
   input wire logic [7:0]  SFR_WDATA,
   input wire logic [7:0]  SFR_RDATA,
   input wire logic        FL_SECTOR_ERASE_GO,
   input wire logic        FL_BLOCK_ERASE_GO,
   input wire logic        FL_WORD_WRITE_GO,
   input wire logic [18:0] FL_ADDR,
   input wire logic [15:0] FL_DATA,
   input wire logic        FL_OP_DONE,
   input wire logic        REWRITE_DONE_IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   ////////////////////////////////////////////////////////////////////////////
   logic       ers_r; // Erase running, one edge behind the design.
   logic       wrt_r; // Word write running, one edge behind.
   logic [3:0] lk_r;  // Shadow of the sticky region locks.
   logic       go;    // Any start pulse.
   logic       eb;    // Erase busy as the design shows it.
   logic       wb;    // Write busy as the design shows it.
   assign go = FL_SECTOR_ERASE_GO | FL_BLOCK_ERASE_GO | FL_WORD_WRITE_GO;
   assign eb = ers_r | FL_SECTOR_ERASE_GO | FL_BLOCK_ERASE_GO;
   assign wb = wrt_r | FL_WORD_WRITE_GO;
   // A done clears both flags, because the engine runs one job at a time.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ers_r <= 1'b0;
         wrt_r <= 1'b0;
         lk_r <= 4'h0;
      end else begin
         ers_r <= go ? eb : (ers_r & ~FL_OP_DONE);
         wrt_r <= go ? FL_WORD_WRITE_GO : (wrt_r & ~FL_OP_DONE);
         if (SFR_WE && SFR_ADDR == frg_pkg::ADDR_LOCK) begin
            lk_r <= lk_r | SFR_WDATA[3:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_go_exclusive: assert property (
      $onehot0({FL_SECTOR_ERASE_GO, FL_BLOCK_ERASE_GO, FL_WORD_WRITE_GO})) else $error("two starts");
   a_busy_blocks: assert property (
      (ers_r || wrt_r) |-> !go) else $error("start while busy");
   a_block_cause: assert property (
      FL_BLOCK_ERASE_GO |-> $past(SFR_WE && SFR_ADDR == frg_pkg::ADDR_ERASE_GO && SFR_WDATA[0]))
      else $error("block start without cause");
   a_sector_cause: assert property (
      FL_SECTOR_ERASE_GO |-> $past(SFR_WE && SFR_ADDR == frg_pkg::ADDR_ERASE_GO
      && SFR_WDATA[1:0] == 2'h2)) else $error("sector start without cause");
   a_word_cause: assert property (
      FL_WORD_WRITE_GO |-> $past(SFR_WE && SFR_ADDR == frg_pkg::ADDR_DATA_HI)
      && FL_DATA[15:8] == $past(SFR_WDATA)) else $error("word start wrong");
   a_seg_valid: assert property (
      go |-> FL_ADDR[18:16] == frg_pkg::SEG_VALID && FL_ADDR[15:11] == 5'h00)
      else $error("start outside segment");
   a_region_lock: assert property (
      (FL_SECTOR_ERASE_GO || FL_WORD_WRITE_GO) |-> !lk_r[FL_ADDR[10:9]])
      else $error("start in locked region");
   a_block_lock: assert property (
      FL_BLOCK_ERASE_GO |-> lk_r == 4'h0) else $error("block start with a lock set");
   a_irq_follow: assert property (
      (ers_r || wrt_r) && FL_OP_DONE |=> REWRITE_DONE_IRQ ##1 !REWRITE_DONE_IRQ)
      else $error("done pulse wrong");
   a_status_read: assert property (
      SFR_RE && SFR_ADDR == frg_pkg::ADDR_STATUS |=> SFR_RDATA == {6'h00, $past(wb), $past(eb)})
      else $error("status read wrong");
   a_lock_read: assert property (
      SFR_RE && SFR_ADDR == frg_pkg::ADDR_LOCK |=> SFR_RDATA == {4'h0, $past(lk_r)})
      else $error("lock read wrong");
   c_sector: cover property (FL_SECTOR_ERASE_GO);
   c_word: cover property (FL_WORD_WRITE_GO);
   c_block: cover property (FL_BLOCK_ERASE_GO);
   c_busy_try: cover property ((ers_r || wrt_r) && SFR_WE && SFR_ADDR == frg_pkg::ADDR_ERASE_GO);
endmodule
bind frg_rewrite_guard frg_guard_properties u_props (.REF_CLK, .RESETN, .SFR_ADDR, .SFR_WE,
   .SFR_RE, .SFR_WDATA, .SFR_RDATA, .FL_SECTOR_ERASE_GO, .FL_BLOCK_ERASE_GO,
   .FL_WORD_WRITE_GO, .FL_ADDR, .FL_DATA, .FL_OP_DONE, .REWRITE_DONE_IRQ);

// file: bench/frg_rewrite_guard_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
// Reset values first, then the table of starts, keys, busy, locks and a second reset.
module frg_rewrite_guard_tb_top;
   typedef struct packed {
      logic [2:0] seg;  // Segment pattern.
      logic       self; // Self rewrite enable.
      logic [7:0] ahi;  // Upper address byte.
      logic [7:0] ctl;  // Erase control byte; zero means a word write.
      logic [2:0] exp;  // Expected {word, block, sector} pulse.
   } frg_row_t;
   frg_row_t    rows [8] = '{'{3'h4, 1'b0, 8'h00, 8'h02, 3'h0}, '{3'h5, 1'b1, 8'h00, 8'h02, 3'h0},
      '{3'h0, 1'b1, 8'h00, 8'h01, 3'h0}, '{3'h4, 1'b1, 8'h08, 8'h02, 3'h0},
      '{3'h4, 1'b1, 8'h06, 8'h02, 3'h1}, '{3'h4, 1'b1, 8'h00, 8'h01, 3'h2},
      '{3'h4, 1'b1, 8'h00, 8'h03, 3'h2}, '{3'h4, 1'b1, 8'h04, 8'h00, 3'h4}};
   logic [15:0] ra [6] = '{16'hF0E5, 16'hF0E6, 16'hF0E7, 16'hF0E8, 16'hF0EA, 16'hF0E9};
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic        we = 1'b0;
   logic        re = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic        slow = 1'b0;
   logic [7:0]  rdata;
   logic        sgo, background_operation, wgo, done, irq;
   logic [18:0] fla;
   logic [15:0] fld;
   logic [2:0]  gov; // Start pulses seen just after the last write.
   int          fail_count = 0;
   int          cmp_count = 0;
   always #10 clk = ~clk;
   frg_rewrite_guard dut (.REF_CLK(clk), .RESETN(rst_n), .SFR_ADDR(addr), .SFR_WE(we),
      .SFR_RE(re), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .FL_SECTOR_ERASE_GO(sgo),
      .FL_BLOCK_ERASE_GO(background_operation), .FL_WORD_WRITE_GO(wgo), .FL_ADDR(fla), .FL_DATA(fld),
      .FL_OP_DONE(done), .REWRITE_DONE_IRQ(irq));
   frg_flash_model eng (.clk(clk), .rst_n(rst_n), .go(sgo | background_operation | wgo), .slow(slow), .done(done));
   ////////////////////////////////////////////////////////////////////////////
   // One write; an idle edge follows so the strobe never toggles twice at once.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
      gov = {wgo, background_operation, sgo};
   endtask
   // One read, compared once the data has registered.
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      re = 1'b1;
      @(negedge clk);
      re = 1'b0;
      `CHK(rdata, e)
   endtask
   task automatic unl();
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_FIRST);
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_SECOND);
   endtask
   // Bounded wait for the completion pulse; running out ends the run.
   task automatic wait_irq();
      for (int n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk);
      `CHK(irq, 1'b1)
      if (irq !== 1'b1) complete_run();
   endtask
   // A start, its pulse, the busy status while it runs, and its end.
   task automatic start(input logic [15:0] a, input logic [7:0] d, input logic [2:0] e);
      wr(a, d);
      `CHK(gov, e)
      if (e != 3'h0) begin
         rd(frg_pkg::ADDR_STATUS, {6'h00, e[2], |e[1:0]});
         wait_irq();
         // Software sees both busy flags low before it tries the next start.
         rd(frg_pkg::ADDR_STATUS, 8'h00);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      foreach (ra[i]) rd(ra[i], 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(frg_pkg::ADDR_SEGMENT, {5'h00, rows[i].seg});
         wr(frg_pkg::ADDR_SELF_EN, {7'h00, rows[i].self});
         wr(frg_pkg::ADDR_TGT_HI, rows[i].ahi);
         wr(frg_pkg::ADDR_TGT_LO, 8'h5A);
         unl();
         if (rows[i].ctl != 8'h00) begin
            start(frg_pkg::ADDR_ERASE_GO, rows[i].ctl, rows[i].exp);
         end else begin
            wr(frg_pkg::ADDR_DATA_LO, 8'h3C);
            start(frg_pkg::ADDR_DATA_HI, 8'hC3, rows[i].exp);
            `CHK(fld, 16'hC33C)
         end
         if (rows[i].exp != 3'h0) `CHK(fla, {3'h4, rows[i].ahi, 8'h5A})
      end
      $display("test table done");
      // The last row used up the arming, so a bare start must be refused.
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h0);
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_FIRST);
      wr(frg_pkg::ADDR_UNLOCK, 8'h00);
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_SECOND);
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h0);
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_FIRST);
      rd(frg_pkg::ADDR_UNLOCK, 8'h00);
      wr(frg_pkg::ADDR_TGT_HI, 8'h02);
      wr(frg_pkg::ADDR_UNLOCK, frg_pkg::KEY_SECOND);
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h1);
      $display("test keys done");
      // A long job keeps busy up while a second armed start is tried.
      slow = 1'b1;
      unl();
      wr(frg_pkg::ADDR_ERASE_GO, 8'h01);
      `CHK(gov, 3'h2)
      unl();
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h0);
      wr(frg_pkg::ADDR_STATUS, 8'hFF);
      rd(frg_pkg::ADDR_STATUS, 8'h01);
      wait_irq();
      rd(frg_pkg::ADDR_STATUS, 8'h00);
      slow = 1'b0;
      $display("test busy done");
      // The refused start kept the arming for the lock cases below.
      wr(frg_pkg::ADDR_LOCK, 8'h01);
      wr(frg_pkg::ADDR_LOCK, 8'h00);
      rd(frg_pkg::ADDR_LOCK, 8'h01);
      wr(frg_pkg::ADDR_TGT_HI, 8'h00);
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h0);
      wr(frg_pkg::ADDR_TGT_HI, 8'h02);
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h1);
      unl();
      start(frg_pkg::ADDR_ERASE_GO, 8'h01, 3'h0);
      wr(frg_pkg::ADDR_LOCK, 8'h08);
      wr(frg_pkg::ADDR_TGT_HI, 8'h06);
      start(frg_pkg::ADDR_DATA_HI, 8'h11, 3'h0);
      wr(frg_pkg::ADDR_TGT_HI, 8'h04);
      start(frg_pkg::ADDR_ERASE_GO, 8'h02, 3'h1);
      $display("test locks done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rd(frg_pkg::ADDR_LOCK, 8'h00);
      $display("test second reset done");
      complete_run();
   end
endmodule

// file: hw/frg_key_if.sv
`timescale 1ns/1ns
// Carries unlock register writes to the sequencer and its armed state back.
interface frg_key_if;
   logic       wr;       // Write to the unlock register this cycle.
   logic [7:0] data;     // Byte written.
   logic       consume;  // An accepted operation starts this cycle.
   logic       armed;    // One operation may start.

   modport ctrl (output wr, output data, output consume, input armed);
   modport seq  (input wr, input data, input consume, output armed);
endinterface

// file: hw/frg_pkg.sv
package frg_pkg;

   // Register byte addresses on the special function register bus.
   localparam logic [15:0] ADDR_TGT_LO   = 16'hF0E0;
   localparam logic [15:0] ADDR_TGT_HI   = 16'hF0E1;
   localparam logic [15:0] ADDR_DATA_LO  = 16'hF0E2;
   localparam logic [15:0] ADDR_DATA_HI  = 16'hF0E3;
   localparam logic [15:0] ADDR_ERASE_GO = 16'hF0E4;
   localparam logic [15:0] ADDR_UNLOCK   = 16'hF0E5;
   localparam logic [15:0] ADDR_SEGMENT  = 16'hF0E6;
   localparam logic [15:0] ADDR_SELF_EN  = 16'hF0E7;
   localparam logic [15:0] ADDR_LOCK     = 16'hF0E8;
   localparam logic [15:0] ADDR_STATUS   = 16'hF0EA;

   // Unlock key values.
   localparam logic [7:0] KEY_FIRST  = 8'hFA;
   localparam logic [7:0] KEY_SECOND = 8'hF5;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_SEG  = 3'h0;
   localparam logic [3:0] RST_LOCK = 4'h0;

   // Field positions.
   localparam int BIT_BLOCK_GO   = 0;
   localparam int BIT_SECTOR_GO  = 1;
   localparam int BIT_SELF_ON    = 0;
   localparam int BIT_ERASE_BSY  = 0;
   localparam int BIT_WRITE_BSY  = 1;
   localparam int BIT_REGION_LSB = 1;
   localparam int BIT_REGION_MSB = 2;
   localparam int BIT_RANGE_LSB  = 3;

   // The single segment pattern that names a real target.
   localparam logic [2:0] SEG_VALID = 3'h4;

   // Unlock sequencer states.
   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_FIRST_SEEN,
      KEY_ARMED
   } frg_key_state_t;

   // Whole state of the unlock sequencer.
   typedef struct packed {
      frg_key_state_t st;
   } frg_seq_state_t;

   // Whole state of the guard.
   typedef struct packed {
      logic [7:0]  tgt_lo;
      logic [7:0]  tgt_hi;
      logic [7:0]  data_lo;
      logic [7:0]  data_hi;
      logic [2:0]  seg;
      logic        self_on;
      logic [3:0]  lock;
      logic        erase_busy;
      logic        word_write_busy;
      logic [7:0]  rdata;
      logic        sector_go;
      logic        block_go;
      logic        word_go;
      logic [18:0] fl_addr;
      logic [15:0] fl_data;
      logic        done_irq;
   } frg_guard_state_t;

endpackage

// file: hw/frg_rewrite_guard.sv
`timescale 1ns/1ns
// Access guard and status for flash self rewrite: unlock, segment, enable,
// region locks, busy flags and the start pulses toward the flash engine.
module frg_rewrite_guard (
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   input  wire logic [15:0] SFR_ADDR,
   input  wire logic        SFR_WE,
   input  wire logic        SFR_RE,
   input  wire logic [7:0]  SFR_WDATA,
   output logic      [7:0]  SFR_RDATA,
   output logic             FL_SECTOR_ERASE_GO,
   output logic             FL_BLOCK_ERASE_GO,
   output logic             FL_WORD_WRITE_GO,
   output logic      [18:0] FL_ADDR,
   output logic      [15:0] FL_DATA,
   input  wire logic        FL_OP_DONE,
   output logic             REWRITE_DONE_IRQ
);

   frg_pkg::frg_guard_state_t s_r;    // Registered state.
   frg_pkg::frg_guard_state_t s_nxt;  // Next state.

   frg_key_if key ();                 // Link to the unlock sequencer.

   logic       wr_tgt_lo;             // Write strobes per register.
   logic       wr_tgt_hi;
   logic       wr_data_lo;
   logic       wr_data_hi;
   logic       wr_erase_go;
   logic       wr_segment;
   logic       wr_self_en;
   logic       wr_lock;
   logic       erase_req;             // An erase start is asked for.
   logic       block_sel;             // The erase asked for is a block erase.
   logic       seg_ok;                // Segment field names a real segment.
   logic       in_range;              // Address lies inside the segment.
   logic       region_locked;         // Addressed 512-byte region is locked.
   logic       common_ok;             // Checks shared by every operation.
   logic       erase_ok;              // Erase request is accepted.
   logic       word_ok;               // Word write request is accepted.
   logic [7:0] rd_mux;                // Read data before its register.

   ////////////////////////////////////////////////////////////////////////////
   // Address decode. Each register answers to exactly one byte address.
   always_comb begin
      wr_tgt_lo   = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_TGT_LO);
      wr_tgt_hi   = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_TGT_HI);
      wr_data_lo  = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_DATA_LO);
      wr_data_hi  = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_DATA_HI);
      wr_erase_go = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_ERASE_GO);
      wr_segment  = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_SEGMENT);
      wr_self_en  = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_SELF_EN);
      wr_lock     = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_LOCK);
   end

   // Unlock writes go to the sequencer; the register keeps no readable copy.
   assign key.wr   = SFR_WE && (SFR_ADDR == frg_pkg::ADDR_UNLOCK);
   assign key.data = SFR_WDATA;

   frg_unlock_seq u_seq (
      .REF_CLK (REF_CLK),
      .RESETN  (RESETN),
      .key     (key)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance checks. They look at the registered settings, so a setting
   // written in the same cycle as a start does not count for that start.
   always_comb begin
      erase_req = wr_erase_go &&
                  (SFR_WDATA[frg_pkg::BIT_BLOCK_GO] || SFR_WDATA[frg_pkg::BIT_SECTOR_GO]);
      // With both bits set, the block erase wins.
      block_sel = SFR_WDATA[frg_pkg::BIT_BLOCK_GO];
      seg_ok    = (s_r.seg == frg_pkg::SEG_VALID);
      // The segment spans 2 KB, so the upper address bits must be zero.
      in_range  = (s_r.tgt_hi[7:frg_pkg::BIT_RANGE_LSB] == '0);
      // Address bits 10:9 pick the 512-byte region.
      region_locked =
         s_r.lock[s_r.tgt_hi[frg_pkg::BIT_REGION_MSB:frg_pkg::BIT_REGION_LSB]];
      common_ok = key.armed && s_r.self_on && seg_ok &&
                  !s_r.erase_busy && !s_r.word_write_busy;
      if (block_sel) begin
         // Any lock bit kills the whole block.
         erase_ok = erase_req && common_ok && in_range && (s_r.lock == '0);
      end else begin
         erase_ok = erase_req && common_ok && in_range && !region_locked;
      end
      word_ok = wr_data_hi && common_ok && in_range && !region_locked;
   end

   // An accepted start spends the arming.
   assign key.consume = erase_ok || word_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux. Write-only locations and unmapped addresses read as zero.
   always_comb begin
      rd_mux = frg_pkg::RST_BYTE;
      case (SFR_ADDR)
         frg_pkg::ADDR_TGT_LO:  rd_mux = s_r.tgt_lo;
         frg_pkg::ADDR_TGT_HI:  rd_mux = s_r.tgt_hi;
         frg_pkg::ADDR_DATA_LO: rd_mux = s_r.data_lo;
         frg_pkg::ADDR_DATA_HI: rd_mux = s_r.data_hi;
         frg_pkg::ADDR_SEGMENT: rd_mux = {5'h00, s_r.seg};
         frg_pkg::ADDR_SELF_EN: rd_mux = {7'h00, s_r.self_on};
         frg_pkg::ADDR_LOCK:    rd_mux = {4'h0, s_r.lock};
         frg_pkg::ADDR_STATUS: begin
            rd_mux[frg_pkg::BIT_ERASE_BSY] = s_r.erase_busy;
            rd_mux[frg_pkg::BIT_WRITE_BSY] = s_r.word_write_busy;
         end
         default: rd_mux = frg_pkg::RST_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state of every register.
   always_comb begin
      s_nxt = s_r;
      // Start pulses and the interrupt last one cycle only.
      s_nxt.sector_go = 1'b0;
      s_nxt.block_go  = 1'b0;
      s_nxt.word_go   = 1'b0;
      s_nxt.done_irq  = 1'b0;

      // Plain setting registers. Address bit 0 is fixed at zero.
      if (wr_tgt_lo) begin
         s_nxt.tgt_lo = {SFR_WDATA[7:1], 1'b0};
      end
      if (wr_tgt_hi) begin
         s_nxt.tgt_hi = SFR_WDATA;
      end
      if (wr_data_lo) begin
         s_nxt.data_lo = SFR_WDATA;
      end
      // The upper byte is stored even when the write it launches is refused.
      if (wr_data_hi) begin
         s_nxt.data_hi = SFR_WDATA;
      end
      if (wr_segment) begin
         s_nxt.seg = SFR_WDATA[2:0];
      end
      if (wr_self_en) begin
         s_nxt.self_on = SFR_WDATA[frg_pkg::BIT_SELF_ON];
      end
      // Locks only accumulate; a zero never clears one.
      if (wr_lock) begin
         s_nxt.lock = s_r.lock | SFR_WDATA[3:0];
      end
      // Writes to the status address fall through untouched.

      // Completion from the engine ends whichever operation ran.
      if (FL_OP_DONE && (s_r.erase_busy || s_r.word_write_busy)) begin
         s_nxt.erase_busy      = 1'b0;
         s_nxt.word_write_busy = 1'b0;
         s_nxt.done_irq        = 1'b1;
      end

      // A refused start changes nothing here, so the busy flags keep their values.
      if (erase_ok) begin
         s_nxt.erase_busy = 1'b1;
         s_nxt.block_go   = block_sel;
         s_nxt.sector_go  = !block_sel;
         s_nxt.fl_addr    = {s_r.seg, s_r.tgt_hi, s_r.tgt_lo};
      end
      if (word_ok) begin
         s_nxt.word_write_busy = 1'b1;
         s_nxt.word_go         = 1'b1;
         s_nxt.fl_addr         = {s_r.seg, s_r.tgt_hi, s_r.tgt_lo};
         s_nxt.fl_data         = {SFR_WDATA, s_r.data_lo};
      end

      // Read data is registered; a read strobe updates it.
      if (SFR_RE) begin
         s_nxt.rdata = rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register. Locks return to zero only here, on reset.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_r.tgt_lo          <= frg_pkg::RST_BYTE;
         s_r.tgt_hi          <= frg_pkg::RST_BYTE;
         s_r.data_lo         <= frg_pkg::RST_BYTE;
         s_r.data_hi         <= frg_pkg::RST_BYTE;
         s_r.seg             <= frg_pkg::RST_SEG;
         s_r.self_on         <= 1'b0;
         s_r.lock            <= frg_pkg::RST_LOCK;
         s_r.erase_busy      <= 1'b0;
         s_r.word_write_busy <= 1'b0;
         s_r.rdata           <= frg_pkg::RST_BYTE;
         s_r.sector_go       <= 1'b0;
         s_r.block_go        <= 1'b0;
         s_r.word_go         <= 1'b0;
         s_r.fl_addr         <= 19'h00000;
         s_r.fl_data         <= 16'h0000;
         s_r.done_irq        <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Every output is a field of the state register.
   assign SFR_RDATA          = s_r.rdata;
   assign FL_SECTOR_ERASE_GO = s_r.sector_go;
   assign FL_BLOCK_ERASE_GO  = s_r.block_go;
   assign FL_WORD_WRITE_GO   = s_r.word_go;
   assign FL_ADDR            = s_r.fl_addr;
   assign FL_DATA            = s_r.fl_data;
   assign REWRITE_DONE_IRQ   = s_r.done_irq;

endmodule

// file: hw/frg_unlock_seq.sv
`timescale 1ns/1ns
// Two-key unlock sequencer for the self rewrite guard.
module frg_unlock_seq (
   input  wire logic  REF_CLK,
   input  wire logic  RESETN,
   frg_key_if.seq     key
);

   frg_pkg::frg_seq_state_t s_r;    // Registered state.
   frg_pkg::frg_seq_state_t s_nxt;  // Next state.

   ////////////////////////////////////////////////////////////////////////////
   // Next state. Only unlock register writes and an accepted start move the sequence, so
   // any other bus traffic in between leaves a pending first key alone.
   always_comb begin
      s_nxt = s_r;
      case (s_r.st)
         frg_pkg::KEY_IDLE: begin
            if (key.wr && key.data == frg_pkg::KEY_FIRST) begin
               s_nxt.st = frg_pkg::KEY_FIRST_SEEN;
            end
         end
         frg_pkg::KEY_FIRST_SEEN: begin
            // Only writes count here; unrelated cycles hold the state.
            if (key.wr) begin
               if (key.data == frg_pkg::KEY_SECOND) begin
                  s_nxt.st = frg_pkg::KEY_ARMED;
               end else begin
                  // Even a repeated first key is discarded; restart needed.
                  s_nxt.st = frg_pkg::KEY_IDLE;
               end
            end
         end
         frg_pkg::KEY_ARMED: begin
            // One accepted start uses the arming up.
            if (key.consume) begin
               s_nxt.st = frg_pkg::KEY_IDLE;
            end
         end
         default: begin
            s_nxt.st = frg_pkg::KEY_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_r.st <= frg_pkg::KEY_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign key.armed = (s_r.st == frg_pkg::KEY_ARMED);

endmodule
